// *** sbc_mode_defs.vh ***
// Constants for the operating-mode controller
// Function
// - Exactly six modes, one at a time
// - Init on power-up and soft reset
// - Stop mode keeps main regulator on
// - Sleep mode turns main regulator off
// - Restart on wake or failure, reset asserted
// - Leave restart after delay into normal
// - Critical failure may enter fail-safe, regulator off
// - Fail-safe held until wake or temp clears
// - Development mode halts watchdog, no failure
// - Development mode forces CAN normal, aux on
// - Test strap in init selects development
// - All modes except fail-safe reachable in development mode
// - Control uses 16-bit SPI frames
// - Strap config picks restart or fail-safe
// - Mode field cleared passing through restart
// - First valid SPI frame in init: normal
// - No trigger in long window: restart in init, else per strap
// - Wake events ignored in init
`ifndef SBC_MODE_DEFS_VH
`define SBC_MODE_DEFS_VH
// Mode codes
`define MODE_INIT     3'h0
`define MODE_NORMAL   3'h1
`define MODE_STOP     3'h2
`define MODE_SLEEP    3'h3
`define MODE_RESTART  3'h4
`define MODE_FAILSAFE 3'h5
// Mode request field codes (0 keeps normal)
`define REQ_NORMAL    2'h0
`define REQ_SLEEP     2'h1
`define REQ_STOP      2'h2
`define REQ_SOFTRST   2'h3
// Frame layout: request field position
`define FRAME_BITS    16
`define REQ_LSB       0
// Timing at 10 MHz (100 ns)
`define CLK_NS        100
`define RD_A_US       10
`define RD_B_US       2
`define LONG_WIN_MS   200
`define RD_A_CYC      ((`RD_A_US * 1000) / `CLK_NS)
`define RD_B_CYC      ((`RD_B_US * 1000) / `CLK_NS)
`define LONG_WIN_CYC  ((`LONG_WIN_MS * 1000000) / `CLK_NS)
`endif

// *** sbc_delay_timer.v ***
// Down-counting delay timer with load and done pulse
module sbc_delay_timer #(
   parameter WIDTH = 24
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_load,
   input wire [WIDTH-1:0] i_count,
   input wire i_run,
   output reg o_done
);
   reg [WIDTH-1:0] count_r;
   reg busy_r;

   // Load wins over running; done is a single pulse on the run cycle that finds the count at one or zero
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_r <= {WIDTH{1'b0}};
         busy_r <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_load) begin
            count_r <= i_count;
            busy_r <= 1'b1;
         end else if (busy_r && i_run) begin
            if (count_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               o_done <= 1'b1;
            end else begin
               count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // sbc_delay_timer

// *** sbc_operating_mode_control.v ***
// Operating-mode state machine with development mode and mode field
`include "sbc_mode_defs.vh"
module sbc_operating_mode_control #(
   parameter LONG_WIN = `LONG_WIN_CYC,
   parameter RD_A = `RD_A_CYC,
   parameter RD_B = `RD_B_CYC
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_frame_valid,
   input wire [15:0] i_frame_data,
   input wire i_frame_len_ok,
   input wire i_wd_trigger,
   input wire i_test_strap,
   input wire i_cfg_strap,
   input wire i_main_uv,
   input wire i_overtemp,
   input wire i_wake_bus,
   input wire i_wake_input,
   input wire i_wake_sense,
   input wire i_wake_gpio,
   input wire i_restart_delay_sel,
   output reg [2:0] o_mode,
   output reg [1:0] o_mode_field,
   output reg o_main_regulator_en,
   output reg o_aux_regulator_en,
   output reg o_can_force_normal,
   output reg o_mcu_reset_n,
   output reg o_dev_mode,
   output reg o_wd_failure,
   output reg o_cfg_failsafe
);
   // ****************************************************
   // State and strap capture
   // ****************************************************
   reg [2:0] mode_r;
   reg [2:0] mode_nxt;
   reg dev_r;
   reg cfg_fs_r;
   reg [1:0] field_r;
   reg [1:0] field_nxt;
   reg [31:0] wd_cnt_r;
   reg wd_fail_r;
   reg wd_armed_r;
   reg prev_restart_r;
   wire wake_any;
   wire frame_ok;
   wire rd_done;
   wire enter_restart;
   wire [23:0] rd_len;

   // ****************************************************
   // Mode decodes shared by the output logic
   // ****************************************************
   // Regulator stays up except in the two power-down modes
   function main_on;
      input [2:0] m;
      begin
         main_on = (m != `MODE_SLEEP) && (m != `MODE_FAILSAFE);
      end
   endfunction

   // Reset held while the supply is off, so the controller never runs unpowered
   function mcu_released;
      input [2:0] m;
      begin
         mcu_released = main_on(m) && (m != `MODE_RESTART);
      end
   endfunction

   assign wake_any = i_wake_bus | i_wake_input | i_wake_sense | i_wake_gpio;
   // Only whole 16-bit frames count as commands
   assign frame_ok = i_frame_valid & i_frame_len_ok;
   assign rd_len = i_restart_delay_sel ? RD_B[23:0] : RD_A[23:0];
   assign enter_restart = (mode_nxt == `MODE_RESTART) && (mode_r != `MODE_RESTART);

   // Straps are caught only while in init, so they cannot change later
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dev_r <= 1'b0;
         cfg_fs_r <= 1'b1; // Safe default: fail-safe on watchdog failure
      end else if (mode_r == `MODE_INIT) begin
         dev_r <= i_test_strap;
         cfg_fs_r <= ~i_cfg_strap;
      end
   end

   // ****************************************************
   // Watchdog: long open window, halted in development
   // ****************************************************
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wd_cnt_r <= 32'h0;
         wd_fail_r <= 1'b0;
         wd_armed_r <= 1'b1;
      end else begin
         wd_fail_r <= 1'b0;
         if (dev_r || !o_mcu_reset_n) begin
            wd_cnt_r <= 32'h0;
         end else if (i_wd_trigger) begin
            wd_cnt_r <= 32'h0;
            wd_armed_r <= 1'b0;
         end else if (wd_armed_r) begin
            if (wd_cnt_r >= LONG_WIN - 1) begin
               wd_fail_r <= 1'b1;
               wd_cnt_r <= 32'h0;
            end else begin
               wd_cnt_r <= wd_cnt_r + 32'h1;
            end
         end
         // Window re-arms after every reset release
         if (mode_r == `MODE_RESTART || mode_r == `MODE_INIT) begin
            wd_armed_r <= 1'b1;
         end
      end
   end

   sbc_delay_timer #(.WIDTH(24)) u_rd_timer (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_load(enter_restart),
      .i_count(rd_len),
      .i_run(~i_main_uv & ~wd_fail_r),
      .o_done(rd_done)
   );

   // ****************************************************
   // Mode state machine
   // ****************************************************
   always @* begin
      mode_nxt = mode_r;
      field_nxt = field_r;
      case (mode_r)
         `MODE_INIT: begin
            // Wake inputs are not looked at here
            if (wd_fail_r || i_main_uv) begin
               mode_nxt = `MODE_RESTART;
            end else if (frame_ok) begin
               mode_nxt = `MODE_NORMAL;
            end
         end
         `MODE_NORMAL, `MODE_STOP: begin
            if (wd_fail_r) begin
               mode_nxt = cfg_fs_r ? `MODE_FAILSAFE : `MODE_RESTART;
            end else if (i_main_uv) begin
               mode_nxt = `MODE_RESTART;
            end else if (frame_ok) begin
               field_nxt = i_frame_data[`REQ_LSB+1:`REQ_LSB];
               case (i_frame_data[`REQ_LSB+1:`REQ_LSB])
                  `REQ_SLEEP: mode_nxt = `MODE_SLEEP;
                  `REQ_STOP: mode_nxt = `MODE_STOP;
                  `REQ_SOFTRST: mode_nxt = `MODE_INIT;
                  default: mode_nxt = `MODE_NORMAL;
               endcase
            end
         end
         `MODE_SLEEP: begin
            if (wake_any) begin
               mode_nxt = `MODE_RESTART;
            end
         end
         `MODE_RESTART: begin
            field_nxt = `REQ_NORMAL;
            if (rd_done) begin
               mode_nxt = `MODE_NORMAL;
            end
         end
         `MODE_FAILSAFE: begin
            // Permanent until a wake or overtemperature release
            if (wake_any || (prev_restart_r && !i_overtemp)) begin
               mode_nxt = `MODE_RESTART;
            end
         end
         default: mode_nxt = `MODE_INIT;
      endcase
      if (mode_nxt == `MODE_RESTART || mode_nxt == `MODE_INIT) begin
         field_nxt = `REQ_NORMAL;
      end
   end

   // Registered mode; prev_restart_r remembers an overtemperature seen while in fail-safe
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_r <= `MODE_INIT;
         field_r <= `REQ_NORMAL;
         prev_restart_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         field_r <= field_nxt;
         if (mode_r != `MODE_FAILSAFE && mode_nxt == `MODE_FAILSAFE) begin
            prev_restart_r <= 1'b0;
         end else if (mode_r == `MODE_FAILSAFE && i_overtemp) begin
            prev_restart_r <= 1'b1;
         end
      end
   end

   // ****************************************************
   // Outputs, all registered; mode, field, regulator and reset from next state
   // ****************************************************
   always @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_mode <= `MODE_INIT;
         o_mode_field <= `REQ_NORMAL;
         o_main_regulator_en <= 1'b1;
         o_aux_regulator_en <= 1'b0;
         o_can_force_normal <= 1'b0;
         o_mcu_reset_n <= 1'b0;
         o_dev_mode <= 1'b0;
         o_wd_failure <= 1'b0;
         o_cfg_failsafe <= 1'b1;
      end else begin
         o_mode <= mode_nxt;
         o_mode_field <= field_nxt;
         // Off in sleep and fail-safe, on in stop
         o_main_regulator_en <= main_on(mode_nxt);
         o_aux_regulator_en <= dev_r;
         o_can_force_normal <= dev_r;
         o_mcu_reset_n <= mcu_released(mode_nxt);
         o_dev_mode <= dev_r;
         o_wd_failure <= wd_fail_r;
         o_cfg_failsafe <= cfg_fs_r;
      end
   end
endmodule // sbc_operating_mode_control

// *** sbc_mode_monitor.sv ***
// Checker of mode controller outputs against its inputs
`include "sbc_mode_defs.vh"
module sbc_mode_monitor (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_frame_valid,
   input wire i_frame_len_ok,
   input wire i_main_uv,
   input wire [2:0] o_mode,
   input wire [1:0] o_mode_field,
   input wire o_main_regulator_en,
   input wire o_aux_regulator_en,
   input wire o_can_force_normal,
   input wire o_mcu_reset_n,
   input wire o_dev_mode,
   input wire o_wd_failure,
   input wire o_cfg_failsafe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Mode properties
   // ****************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   property p_range; o_mode <= `MODE_FAILSAFE; endproperty
   a_range: assert property (p_range) else $error("bad mode code");
   property p_stop; o_mode == `MODE_STOP |-> o_main_regulator_en; endproperty
   a_stop: assert property (p_stop) else $error("stop without regulator");
   property p_sleep; o_mode == `MODE_SLEEP |-> !o_main_regulator_en; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep with regulator");
   property p_fs; o_mode == `MODE_FAILSAFE |-> !o_main_regulator_en; endproperty
   a_fs: assert property (p_fs) else $error("fail-safe with regulator");
   property p_rst; o_mode == `MODE_RESTART |-> !o_mcu_reset_n && o_mode_field == 2'h0; endproperty
   a_rst: assert property (p_rst) else $error("restart outputs wrong");
   // Exit bound is generous: undervoltage may stretch the stay
   property p_exit; $rose(o_mode == `MODE_RESTART) |-> ##[1:300] o_mode == `MODE_NORMAL; endproperty
   a_exit: assert property (p_exit) else $error("restart not left");
   // A window expiry landing on the frame's cycle still wins
   property p_init; o_mode == `MODE_INIT && i_frame_valid && i_frame_len_ok && !i_main_uv
      |=> o_mode == `MODE_NORMAL || (o_wd_failure && o_mode == `MODE_RESTART); endproperty
   a_init: assert property (p_init) else $error("frame in init ignored");
   // Outside init the captured strap picks the target
   property p_wd; o_wd_failure && $past(o_mode) != `MODE_INIT |-> ##[0:2]
      o_mode == (o_cfg_failsafe ? `MODE_FAILSAFE : `MODE_RESTART); endproperty
   a_wd: assert property (p_wd) else $error("wrong failure target");
   // A missed long window in init always restarts
   property p_wdinit; o_wd_failure && $past(o_mode) == `MODE_INIT |->
      o_mode == `MODE_RESTART; endproperty
   a_wdinit: assert property (p_wdinit) else $error("init failure not restart");
   property p_devwd; o_dev_mode |-> !o_wd_failure; endproperty
   a_devwd: assert property (p_devwd) else $error("failure in development");
   property p_devout; o_dev_mode |-> o_can_force_normal && o_aux_regulator_en; endproperty
   a_devout: assert property (p_devout) else $error("development outputs");
   c_sleep: cover property (o_mode == `MODE_SLEEP);
   c_fs: cover property (o_mode == `MODE_FAILSAFE);
   c_dev: cover property (o_dev_mode && o_mode == `MODE_SLEEP);
endmodule // sbc_mode_monitor
bind sbc_operating_mode_control sbc_mode_monitor i_mon (.i_clock, .i_sys_rst, .i_frame_valid,
   .i_frame_len_ok, .i_main_uv, .o_mode, .o_mode_field, .o_main_regulator_en,
   .o_aux_regulator_en, .o_can_force_normal, .o_mcu_reset_n, .o_dev_mode, .o_wd_failure,
   .o_cfg_failsafe);

// *** sbc_mcu_model.sv ***
// Controller model handing 16-bit words, whole or flagged short, and watchdog triggers
module sbc_mcu_model (
   input wire logic i_clock,
   input wire logic i_send,
   input wire logic i_short,
   input wire logic [15:0] i_word,
   output logic o_frame_valid,
   output logic [15:0] o_frame_data,
   output logic o_frame_len_ok,
   output logic o_wd_trigger
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {o_frame_valid, o_frame_data, o_frame_len_ok, o_wd_trigger} = 19'h00000;
   // One word per request; idle data toggles so stale values never match
   always @(posedge i_clock) begin
      o_frame_valid <= i_send;
      o_frame_data <= i_send ? i_word : ~o_frame_data;
      o_frame_len_ok <= !i_short;
      o_wd_trigger <= i_send && !i_short;
   end
endmodule // sbc_mcu_model

// *** sbc_operating_mode_control_tb_top.sv ***
// Self-checking bench of the operating-mode controller
module sbc_operating_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Stimulus and model
   // ****************
   logic i_clock = 0, i_sys_rst = 1, send = 0, shrt = 0, i_test_strap = 0, i_cfg_strap = 1;
   logic i_main_uv = 0, i_overtemp = 0, i_restart_delay_sel = 0;
   logic [3:0] wk = 4'h0;
   logic [15:0] word = 16'h0000;
   logic [31:0] r;
   wire fv, flo, wdt, o_main_regulator_en, o_aux_regulator_en, o_can_force_normal;
   wire o_mcu_reset_n, o_dev_mode, o_wd_failure, o_cfg_failsafe;
   wire [15:0] fd;
   wire [2:0] o_mode;
   wire [1:0] o_mode_field;
   int failures = 0, compares = 0, seed = 32'h4AC662C3, exp_mode = 0, k;
   always #50 i_clock = ~i_clock;
   sbc_mcu_model i_mcu (.i_clock, .i_send(send), .i_short(shrt), .i_word(word),
      .o_frame_valid(fv), .o_frame_data(fd), .o_frame_len_ok(flo), .o_wd_trigger(wdt));
   // Short window and delays keep the run brief
   sbc_operating_mode_control #(.LONG_WIN(60), .RD_A(20), .RD_B(8)) i_dut (.i_clock,
      .i_sys_rst, .i_frame_valid(fv), .i_frame_data(fd), .i_frame_len_ok(flo),
      .i_wd_trigger(wdt), .i_test_strap, .i_cfg_strap, .i_main_uv, .i_overtemp,
      .i_wake_bus(wk[0]), .i_wake_input(wk[1]), .i_wake_sense(wk[2]), .i_wake_gpio(wk[3]),
      .i_restart_delay_sel, .o_mode, .o_mode_field, .o_main_regulator_en, .o_aux_regulator_en,
      .o_can_force_normal, .o_mcu_reset_n, .o_dev_mode, .o_wd_failure, .o_cfg_failsafe);
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #10;
   endtask
   // Frames are refused in sleep, restart and fail-safe
   function automatic int model(int m, logic [1:0] q);
      if (m >= 3) return m;
      if (m == 0) return 1;
      return q == 2'h0 ? 1 : q == 2'h1 ? 3 : q == 2'h2 ? 2 : 0;
   endfunction
   task automatic frame(input logic [15:0] w, input logic s);
      word = w;
      shrt = s;
      send = 1;
      tick(1);
      send = 0;
      tick(2);
      if (!s) exp_mode = model(exp_mode, w[1:0]);
      chk("mode after frame", o_mode, exp_mode);
   endtask
   task automatic wait_mode(input int m);
      for (k = 0; k < 3000 && o_mode !== m; k++) tick(1);
      exp_mode = m;
      chk("mode reached", o_mode, m);
   endtask
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #(100 * 20000);
      failures++;
      test_done;
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      tick(4);
      chk("reset mode", {o_mode, o_mcu_reset_n}, 4'h0);
      i_sys_rst = 0;
      tick(2);
      chk("init regulator", o_main_regulator_en, 1);
      wk = 4'hF;
      tick(1);
      wk = 4'h0;
      chk("wake in init", o_mode, 0);
      frame(16'h0000, 1);
      r = $random(seed);
      frame({r[15:2], 2'h0}, 0);
      frame(16'h0002, 0);
      chk("stop regulator", o_main_regulator_en, 1);
      frame(16'h0000, 0);
      for (int w = 0; w < 4; w++) begin
         frame(16'h0001, 0);
         chk("sleep regulator", o_main_regulator_en, 0);
         frame(16'h0000, 0);
         i_restart_delay_sel = w[0];
         wk[w] = 1;
         tick(1);
         wk = 4'h0;
         chk("wake restart", {o_mode, o_mode_field, o_mcu_reset_n}, 6'h20);
         wait_mode(1);
         chk("delay", k inside {[(w[0] ? 8 : 20) - 5 : (w[0] ? 8 : 20) + 3]}, 1);
      end
      i_main_uv = 1;
      tick(5);
      chk("uv restart", o_mode, 4);
      i_main_uv = 0;
      wait_mode(1);
      for (int v = 0; v < 3; v++) begin
         i_cfg_strap = (v == 1);
         frame(16'h0003, 0);
         wait_mode(v == 1 ? 4 : 5);
         chk("config capture", o_cfg_failsafe, v != 1);
         chk("failure regulator", o_main_regulator_en, v == 1);
         wk[0] = (v == 0);
         i_overtemp = (v == 2);
         tick(2);
         wk = 4'h0;
         i_overtemp = 0;
         wait_mode(1);
      end
      i_test_strap = 1;
      frame(16'h0003, 0);
      tick(100);
      chk("held in init", {o_mode, o_wd_failure}, 4'h0);
      chk("dev outputs", {o_dev_mode, o_can_force_normal, o_aux_regulator_en}, 3'h7);
      frame(16'h0000, 0);
      frame(16'h0001, 0);
      test_done;
   end
endmodule // sbc_operating_mode_control_tb_top
